// file: design/cdsi_core.sv
// Codec serial interface core with AXI4-Lite register slave
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ns
module cdsi_core #(
    parameter int BCG_W = 12
) (
    input logic aclk,
    input logic aresetn,
    input logic [7:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [7:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic bit_clock_pin_in,
    output logic bit_clock_pin_out,
    output logic bit_clock_pin_oe,
    input logic frame_sync_pin_in,
    output logic frame_sync_pin_out,
    output logic frame_sync_pin_oe,
    output logic serial_out_pin,
    output logic serial_out_pin_oe,
    input logic serial_in_pin
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic awv;
        logic wv;
        logic [7:0] awa;
        logic [31:0] wd;
        logic [3:0] wstb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [5:0] ctrl1;
        logic [3:0] wlen;
        logic [3:0] fl;
        logic [BCG_W-1:0] bcg;
        logic [7:0][15:0] bufm;
        logic ck_s1;
        logic ck_s2;
        logic ck_p;
        logic fs_s1;
        logic fs_s2;
        logic fs_smp;
        logic di_s1;
        logic di_s2;
        logic [BCG_W-1:0] div;
        logic bclk;
        cdsi_pkg::cdsi_state_t st;
        logic [15:0] sh;
        logic [4:0] bitc;
        logic [3:0] wordc;
        logic [7:0] fbit;
        logic [1:0] ptr;
        logic fs_o;
        logic fs_oe;
        logic bclk_oe;
        logic so;
        logic so_oe;
    } cdsi_st_t;

    cdsi_st_t s_r;
    cdsi_st_t s_nxt;
    logic en;
    logic ckd;
    logic idm;
    logic fsd;
    logic ac;
    logic run;
    logic tog;
    logic rise;
    logic fall;
    logic word_end;
    logic frame_end;
    logic start;
    logic txing;
    logic store;
    logic fs_lvl;
    logic [4:0] wl;
    logic [3:0] shamt;
    logic [15:0] sh_in;
    logic [15:0] rx_word;
    logic [31:0] wr_mask;
    logic [31:0] wr_word;
    cdsi_pkg::cdsi_mode_t mode;

    // ****************************************
    // Register access helpers
    // ****************************************
    function automatic logic is_buf(input logic [7:0] a, input logic [7:0] base);
        return (a & cdsi_pkg::BUF_MASK) == base;
    endfunction : is_buf

    function automatic logic reg_hit(input logic [7:0] a);
        return a == cdsi_pkg::CTRL1_ADDR || a == cdsi_pkg::CTRL2_ADDR || a == cdsi_pkg::STAT_ADDR
            || is_buf(a, cdsi_pkg::TXBUF_ADDR) || is_buf(a, cdsi_pkg::RXBUF_ADDR);
    endfunction : reg_hit

    function automatic logic [31:0] reg_rd(input cdsi_st_t s, input logic [7:0] a);
        logic [31:0] v;
        logic [1:0] i;
        v = '0;
        i = a[cdsi_pkg::WIDX_LSB +: cdsi_pkg::PTR_W];
        if (a == cdsi_pkg::CTRL1_ADDR) begin
            v[cdsi_pkg::CTRL1_W-1:0] = s.ctrl1;
        end else if (a == cdsi_pkg::CTRL2_ADDR) begin
            v[cdsi_pkg::WLEN_LSB +: 4] = s.wlen;
            v[cdsi_pkg::FL_LSB +: 4] = s.fl;
            v[cdsi_pkg::BCG_LSB +: BCG_W] = s.bcg;
        end else if (a == cdsi_pkg::STAT_ADDR) begin
            v[cdsi_pkg::PTR_LSB +: cdsi_pkg::PTR_W] = s.ptr;
            v[cdsi_pkg::RUN_BIT] = s.st == cdsi_pkg::ST_RUN;
            v[cdsi_pkg::FBIT_LSB +: 8] = s.fbit;
        end else if (is_buf(a, cdsi_pkg::TXBUF_ADDR)) begin
            v[cdsi_pkg::SHIFT_W-1:0] = s.bufm[{1'b1, i}];
        end else if (is_buf(a, cdsi_pkg::RXBUF_ADDR)) begin
            v[cdsi_pkg::SHIFT_W-1:0] = s.bufm[{1'b0, i}];
        end
        return v;
    endfunction : reg_rd

    // ****************************************
    // Decoded controls
    // ****************************************
    assign en = s_r.ctrl1[cdsi_pkg::EN_BIT];
    assign ckd = s_r.ctrl1[cdsi_pkg::CKD_BIT];
    assign idm = s_r.ctrl1[cdsi_pkg::IDM_BIT];
    assign fsd = s_r.ctrl1[cdsi_pkg::FSD_BIT];
    assign mode = cdsi_pkg::cdsi_mode_t'(s_r.ctrl1[cdsi_pkg::MODE_LSB +: 2]);
    assign ac = mode == cdsi_pkg::MODE_AC16 || mode == cdsi_pkg::MODE_AC20;
    assign run = s_r.st == cdsi_pkg::ST_RUN;

    for (genvar i = 0; i < 4; i++) begin : g_mask
        assign wr_mask[8*i +: 8] = {8{s_r.wstb[i]}};
    end
    assign wr_word = (reg_rd(s_r, s_r.awa) & ~wr_mask) | (s_r.wd & wr_mask);

    // Bit clock edges, generated or received
    assign tog = (s_r.bcg != '0) && (s_r.div == s_r.bcg);
    assign rise = ckd ? (s_r.ck_s2 && !s_r.ck_p) : (tog && !s_r.bclk);
    assign fall = ckd ? (!s_r.ck_s2 && s_r.ck_p) : (tog && s_r.bclk);

    // Word and frame geometry
    assign wl = (mode == cdsi_pkg::MODE_AC20 && s_r.wordc != '0) ? cdsi_pkg::AC20_LAST :
                ac ? cdsi_pkg::AC16_LAST : {1'b0, s_r.wlen};
    assign word_end = s_r.bitc == wl;
    assign frame_end = ac ? s_r.fbit == cdsi_pkg::FRAME_LAST :
                       (word_end && s_r.wordc == s_r.fl);
    assign start = !fsd || (mode == cdsi_pkg::MODE_I2S ? s_r.fs_s2 != s_r.fs_smp : s_r.fs_s2);
    assign txing = run && s_r.bitc < cdsi_pkg::SHIFT_BITS;
    assign store = en && fall && run && word_end;

    // Shift path and left justification
    assign sh_in = {s_r.sh[14:0], s_r.di_s2};
    assign shamt = ac ? 4'h0 : ~s_r.wlen;
    assign rx_word = (s_r.bitc < cdsi_pkg::SHIFT_BITS ? sh_in : s_r.sh) << shamt;

    always_comb begin
        unique case (mode)
            cdsi_pkg::MODE_MULTI: fs_lvl = frame_end;
            cdsi_pkg::MODE_I2S: fs_lvl = word_end ? !s_r.wordc[0] : s_r.wordc[0];
            cdsi_pkg::MODE_AC16,
            cdsi_pkg::MODE_AC20: fs_lvl = s_r.fbit == cdsi_pkg::FRAME_LAST
                                       || s_r.fbit < cdsi_pkg::AC_SYNC_LAST;
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_nxt = s_r;
        // AXI write channel
        if (s_axi_awvalid && s_r.awready) begin
            s_nxt.awv = 1'b1;
            s_nxt.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_r.wready) begin
            s_nxt.wv = 1'b1;
            s_nxt.wd = s_axi_wdata;
            s_nxt.wstb = s_axi_wstrb;
        end
        if (s_axi_bready && s_r.bvalid) begin
            s_nxt.bvalid = 1'b0;
        end
        if (s_r.awv && s_r.wv && !s_r.bvalid) begin
            s_nxt.awv = 1'b0;
            s_nxt.wv = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = reg_hit(s_r.awa) ? cdsi_pkg::RESP_OKAY : cdsi_pkg::RESP_SLVERR;
            if (s_r.awa == cdsi_pkg::CTRL1_ADDR) begin
                s_nxt.ctrl1 = wr_word[cdsi_pkg::CTRL1_W-1:0];
            end else if (s_r.awa == cdsi_pkg::CTRL2_ADDR) begin
                s_nxt.wlen = wr_word[cdsi_pkg::WLEN_LSB +: 4];
                s_nxt.fl = wr_word[cdsi_pkg::FL_LSB +: 4];
                s_nxt.bcg = wr_word[cdsi_pkg::BCG_LSB +: BCG_W];
            end else if (is_buf(s_r.awa, cdsi_pkg::TXBUF_ADDR)) begin
                s_nxt.bufm[{1'b1, s_r.awa[cdsi_pkg::WIDX_LSB +: cdsi_pkg::PTR_W]}] = wr_word[15:0];
            end
        end
        s_nxt.awready = !s_nxt.awv && !s_nxt.bvalid;
        s_nxt.wready = !s_nxt.wv && !s_nxt.bvalid;
        // AXI read channel
        if (s_axi_rready && s_r.rvalid) begin
            s_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_r.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = reg_rd(s_r, s_axi_araddr);
            s_nxt.rresp = reg_hit(s_axi_araddr) ? cdsi_pkg::RESP_OKAY : cdsi_pkg::RESP_SLVERR;
        end
        s_nxt.arready = !s_nxt.rvalid;
        // Pin synchronisers; serial input is only ever sampled
        s_nxt.ck_s1 = bit_clock_pin_in;
        s_nxt.ck_s2 = s_r.ck_s1;
        s_nxt.ck_p = s_r.ck_s2;
        s_nxt.fs_s1 = frame_sync_pin_in;
        s_nxt.fs_s2 = s_r.fs_s1;
        s_nxt.di_s1 = serial_in_pin;
        s_nxt.di_s2 = s_r.di_s1;
        // Bit clock generator, independent of module enable
        if (s_r.bcg == '0) begin
            s_nxt.div = '0;
            s_nxt.bclk = 1'b0;
        end else if (tog) begin
            s_nxt.div = '0;
            s_nxt.bclk = !s_r.bclk;
        end else begin
            s_nxt.div = s_r.div + 1'b1;
        end
        s_nxt.bclk_oe = !ckd && (en || s_r.bcg != '0);
        if (!en) begin
            // Disabled: counters cleared, frame sync and serial output pins released
            s_nxt.st = cdsi_pkg::ST_IDLE;
            s_nxt.bitc = '0;
            s_nxt.wordc = '0;
            s_nxt.fbit = '0;
            s_nxt.ptr = '0;
            s_nxt.fs_smp = 1'b0;
            s_nxt.fs_o = 1'b0;
            s_nxt.fs_oe = 1'b0;
            s_nxt.so = 1'b0;
            s_nxt.so_oe = 1'b0;
        end else begin
            s_nxt.fs_oe = !fsd;
            if (fall) begin
                s_nxt.fs_smp = s_r.fs_s2;
                if (run) begin
                    if (s_r.bitc < cdsi_pkg::SHIFT_BITS) begin
                        s_nxt.sh = sh_in;
                    end
                    s_nxt.bitc = s_r.bitc + 5'h01;
                    s_nxt.fbit = s_r.fbit + 8'h01;
                    if (word_end) begin
                        s_nxt.bitc = '0;
                        s_nxt.bufm[{1'b0, s_r.ptr}] = rx_word;
                        s_nxt.ptr = s_r.ptr + 2'h1;
                        s_nxt.sh = s_r.bufm[{1'b1, s_r.ptr + 2'h1}];
                        s_nxt.wordc = frame_end ? 4'h0 : s_r.wordc + 4'h1;
                    end
                    if (frame_end) begin
                        s_nxt.fbit = '0;
                        if (fsd) begin
                            s_nxt.st = cdsi_pkg::ST_IDLE;
                        end
                    end
                end else if (start) begin
                    s_nxt.st = cdsi_pkg::ST_RUN;
                    s_nxt.sh = s_r.bufm[{1'b1, s_r.ptr}];
                end
            end
            if (rise) begin
                s_nxt.so = txing && s_r.sh[15];
                s_nxt.so_oe = txing || !idm;
                s_nxt.fs_o = !fsd && run && fs_lvl;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.st <= cdsi_pkg::ST_IDLE;
            s_r.ctrl1 <= cdsi_pkg::CTRL1_RST;
            s_r.wlen <= cdsi_pkg::WLEN_RST;
            s_r.fl <= cdsi_pkg::FL_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign s_axi_awready = s_r.awready;
    assign s_axi_wready = s_r.wready;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign s_axi_rvalid = s_r.rvalid;
    assign bit_clock_pin_out = s_r.bclk;
    assign bit_clock_pin_oe = s_r.bclk_oe;
    assign frame_sync_pin_out = s_r.fs_o;
    assign frame_sync_pin_oe = s_r.fs_oe;
    assign serial_out_pin = s_r.so;
    assign serial_out_pin_oe = s_r.so_oe;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    bclk_dir_a: assert property (en && !ckd |=> bit_clock_pin_oe)
        else $error("bit clock not driven while enabled");
    bclk_alone_a: assert property (!en && !ckd && s_r.bcg != '0 |=> bit_clock_pin_oe)
        else $error("generator did not take bit clock pin");
    idle_zero_a: assert property (en && rise && !txing && !idm |=> serial_out_pin_oe && !serial_out_pin)
        else $error("idle output not driven low");
    fs_dir_a: assert property (fsd || !en |=> !frame_sync_pin_oe)
        else $error("frame sync driven in slave mode");
    rx_ljust_a: assert property (store && !ac |=>
        (s_r.bufm[{1'b0, $past(s_r.ptr)}] << ({1'b0, $past(s_r.wlen)} + 5'h01)) == 16'h0000)
        else $error("received word low bits not zero");
    ptr_step_a: assert property (store |=> s_r.ptr == $past(s_r.ptr) + 2'h1)
        else $error("buffer pointer did not advance");
    disable_clr_a: assert property (!en |=> s_r.ptr == '0 && s_r.fbit == '0 && !serial_out_pin_oe)
        else $error("disable did not reset module");
    word_len_a: assert property (run && !ac |-> s_r.bitc <= {1'b0, s_r.wlen})
        else $error("word counter beyond word size");
    frame_len_a: assert property (run && !ac |-> s_r.wordc <= s_r.fl)
        else $error("frame counter beyond frame length");
    ac_wrap_a: assert property (fall && run && ac && s_r.fbit == cdsi_pkg::FRAME_LAST |=> s_r.fbit == '0)
        else $error("AC-Link frame not 256 bits");
    ac_sync_a: assert property (en && rise && run && !fsd && ac |=> frame_sync_pin_out ==
        ($past(s_r.fbit) == cdsi_pkg::FRAME_LAST || $past(s_r.fbit) < cdsi_pkg::AC_SYNC_LAST))
        else $error("AC-Link sync shape wrong");
    multi_pulse_a: assert property (en && rise && run && !fsd && mode == cdsi_pkg::MODE_MULTI
        |=> frame_sync_pin_out == $past(frame_end))
        else $error("multi-channel sync pulse wrong");
    slave_start_a: assert property (en && fall && fsd && !run && s_r.fs_s2 && mode == cdsi_pkg::MODE_MULTI
        |=> run && s_r.bitc == '0)
        else $error("slave frame did not start");

    ac_frame_c: cover property (store && ac && frame_end);
    slave_start_c: cover property (en && fall && fsd && !run && start);
    multi_frame_c: cover property (store && !ac && frame_end);
    i2s_sync_c: cover property (en && mode == cdsi_pkg::MODE_I2S && $rose(frame_sync_pin_out));
endmodule : cdsi_core

// file: pkg/cdsi_pkg.sv
// Constants and types shared by the codec serial interface core
package cdsi_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL1_ADDR = 8'h00;
    localparam logic [7:0] CTRL2_ADDR = 8'h04;
    localparam logic [7:0] STAT_ADDR = 8'h08;
    localparam logic [7:0] TXBUF_ADDR = 8'h10;
    localparam logic [7:0] RXBUF_ADDR = 8'h20;
    localparam logic [7:0] BUF_MASK = 8'hf0;
    localparam int WIDX_LSB = 2;
    // ****************************************
    // Control word one fields
    // ****************************************
    localparam int CTRL1_W = 6;
    localparam int EN_BIT = 0;
    localparam int CKD_BIT = 1;
    localparam int IDM_BIT = 2;
    localparam int FSD_BIT = 3;
    localparam int MODE_LSB = 4;
    localparam logic [5:0] CTRL1_RST = 6'h00;
    // ****************************************
    // Control word two fields
    // ****************************************
    localparam int WLEN_LSB = 0;
    localparam int FL_LSB = 4;
    localparam int BCG_LSB = 16;
    localparam logic [3:0] WLEN_RST = 4'hf;
    localparam logic [3:0] FL_RST = 4'h1;
    // ****************************************
    // Status fields
    // ****************************************
    localparam int PTR_LSB = 0;
    localparam int RUN_BIT = 2;
    localparam int FBIT_LSB = 8;
    // ****************************************
    // Link geometry
    // ****************************************
    localparam int SHIFT_W = 16;
    localparam int PTR_W = 2;
    localparam logic [4:0] SHIFT_BITS = 5'h10;
    localparam logic [4:0] AC16_LAST = 5'h0f;
    localparam logic [4:0] AC20_LAST = 5'h13;
    localparam logic [7:0] FRAME_LAST = 8'hff;
    localparam logic [7:0] AC_SYNC_LAST = 8'h0f;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Frame sync modes
    typedef enum logic [1:0] {
        MODE_MULTI = 2'h0,
        MODE_I2S = 2'h1,
        MODE_AC16 = 2'h2,
        MODE_AC20 = 2'h3
    } cdsi_mode_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_RUN = 2'h2
    } cdsi_state_t;
endpackage : cdsi_pkg

// file: testbench/cdsi_codec_model.sv
// Behavioural codec that clocks slave frames into the core
`timescale 1ns/1ns
module cdsi_codec_model (
    output logic bclk,
    output logic fsync,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe
);
    int half = 80;
    logic idle_oe;
    logic idle_v;
    initial begin
        {bclk, fsync, sdi, idle_oe, idle_v} = '0;
    end
    // ****************************************
    // Frame: sync bit, n data bits, one idle bit
    // ****************************************
    task automatic frame(input logic [15:0] w, input int n, output logic [15:0] got);
        got = 16'h0000;
        #5;
        for (int i = -1; i <= n; i++) begin
            bclk = 1'b1;
            fsync = (i < 0);
            sdi = (i >= 0 && i < n) ? w[15 - i] : ~sdi;
            #(half) bclk = 1'b0;
            #(half - 1);
            if (i >= 0 && i < n) got[15 - i] = sdo;
            idle_oe = sdo_oe;
            idle_v = sdo;
            #1;
        end
    endtask : frame
endmodule : cdsi_codec_model

// file: testbench/codec_serial_interface_core_tb.sv
// Self-checking bench for the codec serial interface core
`timescale 1ns/1ns
module codec_serial_interface_core_tb;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, seed;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic bc_out, bc_oe, fs_out, fs_oe, so, so_oe, m_bclk, m_fs, m_sdi, bc_pin, fs_pin;
    logic [15:0] tx [$];
    int miscompares = 0;
    int comparisons = 0;
    assign bc_pin = bc_oe ? bc_out : m_bclk;
    assign fs_pin = fs_oe ? fs_out : m_fs;
    always #10 aclk = ~aclk;
    cdsi_core i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bit_clock_pin_in(bc_pin),
        .bit_clock_pin_out(bc_out), .bit_clock_pin_oe(bc_oe), .frame_sync_pin_in(fs_pin),
        .frame_sync_pin_out(fs_out), .frame_sync_pin_oe(fs_oe), .serial_out_pin(so),
        .serial_out_pin_oe(so_oe), .serial_in_pin(m_sdi)
    );
    cdsi_codec_model i_codec (.bclk(m_bclk), .fsync(m_fs), .sdi(m_sdi), .sdo(so), .sdo_oe(so_oe));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic wrap_up;
        if (miscompares == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        for (int i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                chk({30'h0, bresp}, {30'h0, er});
                bready <= 1'b0;
                return;
            end
        end
        miscompares++;
        wrap_up();
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        for (int i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                chk(rdata & m, e);
                chk({30'h0, rresp}, {30'h0, er});
                rready <= 1'b0;
                return;
            end
        end
        miscompares++;
        wrap_up();
    endtask : rd
    task automatic runs(output int hi, output int lo);
        logic p;
        int st;
        {p, hi, lo, st} = '0;
        for (int i = 0; i < 5000 && st < 4; i++) begin
            @(posedge aclk);
            #1;
            if (bc_out === 1'b1 && p === 1'b0) begin
                case (st)
                    0: if (fs_out === 1'b0) st = 1;
                    1: if (fs_out === 1'b1) {st, hi} = {32'd2, 32'd1};
                    2: if (fs_out === 1'b1) hi++; else {st, lo} = {32'd3, 32'd1};
                    default: if (fs_out === 1'b0) lo++; else st = 4;
                endcase
            end
            p = bc_out;
        end
        if (st != 4) begin
            miscompares++;
            wrap_up();
        end
    endtask : runs
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        int n, hi, lo, wl, eh, el;
        logic [15:0] w, got, mh;
        logic [31:0] c2;
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        seed = 32'h65f928c0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(cdsi_pkg::CTRL1_ADDR, '1, 32'h0, cdsi_pkg::RESP_OKAY);
        rd(cdsi_pkg::CTRL2_ADDR, '1, 32'h1f, cdsi_pkg::RESP_OKAY);
        rd(8'h40, '1, 32'h0, cdsi_pkg::RESP_SLVERR);
        wr(8'h30, '1, cdsi_pkg::RESP_SLVERR);
        wr(cdsi_pkg::STAT_ADDR, '1, cdsi_pkg::RESP_OKAY);
        rd(cdsi_pkg::STAT_ADDR, '1, 32'h0, cdsi_pkg::RESP_OKAY);
        chk({29'h0, bc_oe, fs_oe, so_oe}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            tx.push_back(seed[15:0]);
            wr(cdsi_pkg::TXBUF_ADDR + 8'(4 * i), {16'h0, tx[i]}, cdsi_pkg::RESP_OKAY);
        end
        rd(cdsi_pkg::TXBUF_ADDR + 8'h4, '1, {16'h0, tx[1]}, cdsi_pkg::RESP_OKAY);
        wr(cdsi_pkg::CTRL2_ADDR, 32'h0000000f, cdsi_pkg::RESP_OKAY);
        wr(cdsi_pkg::CTRL1_ADDR, 32'h0000000f, cdsi_pkg::RESP_OKAY);
        chk({30'h0, bc_oe, fs_oe}, 32'h0);
        for (int k = 0; k < 6; k++) begin
            n = (k == 5) ? 12 : 16;
            if (k == 5) wr(cdsi_pkg::CTRL2_ADDR, 32'h0000000b, cdsi_pkg::RESP_OKAY);
            if (k == 3) wr(cdsi_pkg::CTRL1_ADDR, 32'h0000000b, cdsi_pkg::RESP_OKAY);
            if (k == 4) wr(cdsi_pkg::CTRL1_ADDR, 32'h0000001b, cdsi_pkg::RESP_OKAY);
            seed = lfsr(seed);
            w = seed[15:0];
            mh = 16'hffff << (16 - n);
            i_codec.frame(w, n, got);
            chk({16'h0, got & mh}, {16'h0, tx[k % 4] & mh});
            if (k < 3) chk({31'h0, i_codec.idle_oe}, 32'h0);
            if (k >= 3) chk({30'h0, i_codec.idle_oe, i_codec.idle_v}, 32'h2);
            rd(cdsi_pkg::RXBUF_ADDR + 8'(4 * (k % 4)), '1, {16'h0, w & mh}, cdsi_pkg::RESP_OKAY);
            rd(cdsi_pkg::STAT_ADDR, 32'h3, (k + 1) % 4, cdsi_pkg::RESP_OKAY);
        end
        wr(cdsi_pkg::CTRL1_ADDR, 32'h0, cdsi_pkg::RESP_OKAY);
        rd(cdsi_pkg::STAT_ADDR, 32'h3, 32'h0, cdsi_pkg::RESP_OKAY);
        wr(cdsi_pkg::CTRL2_ADDR, 32'h0001001f, cdsi_pkg::RESP_OKAY);
        rd(cdsi_pkg::CTRL2_ADDR, '1, 32'h0001001f, cdsi_pkg::RESP_OKAY);
        chk({29'h0, bc_oe, fs_oe, so_oe}, 32'h4);
        for (int m = 0; m < 4; m++) begin
            c2 = (m == 0) ? 32'h0001001f : (m == 1) ? 32'h00010017 : 32'h00010053;
            wl = (int'(c2[3:0]) + 1) * (int'(c2[7:4]) + 1);
            eh = (m == 0) ? 1 : (m == 1) ? wl / 2 : 16;
            el = (m == 0) ? wl - 1 : (m == 1) ? wl / 2 : 240;
            wr(cdsi_pkg::CTRL2_ADDR, c2, cdsi_pkg::RESP_OKAY);
            wr(cdsi_pkg::CTRL1_ADDR, {26'h0, 2'(m), 4'h1}, cdsi_pkg::RESP_OKAY);
            rd(cdsi_pkg::CTRL1_ADDR, '1, {26'h0, 2'(m), 4'h1}, cdsi_pkg::RESP_OKAY);
            chk({30'h0, bc_oe, fs_oe}, 32'h3);
            runs(hi, lo);
            chk(hi, eh);
            chk(lo, el);
            wr(cdsi_pkg::CTRL1_ADDR, 32'h0, cdsi_pkg::RESP_OKAY);
        end
        wrap_up();
    end
endmodule : codec_serial_interface_core_tb
